// ---- uart_regmap_pkg.sv ----
// Functional notes
// - modem control bit 4 set enters internal loopback, clear leaves it
// - loopback leaves all normal functions running, flow control included
// - loopback feeds transmit shift output straight into receive shift input
// - loopback holds the serial transmit pin at mark, logic 1
// - loopback drives request-to-send and terminal-ready pins de-asserted
// - loopback ignores the four modem status input pins entirely
// - three address lines with chip select pick the register
// - address 0, divisor access clear: read receive, write transmit holding
// - divisor access set: addresses 0 and 1 reach divisor low and high
// - divisor access set, both divisor bytes zero: reads return revision, identity
// - address 1, divisor access clear: interrupt enable, read/write
// - address 2 without key: read interrupt status, write fifo control
// - key 0xbf in line control: address 2 is enhanced function
// - key mode: addresses 4 to 7 are resume one, two, pause one, two
// - line control at address 3 always read/write; bit 7 divisor access
// - no key: address 4 modem control, 5 line status, writes reserved
// - no key: address 6 modem status read-only, 7 scratch byte
// - extended bits work only with enhanced bit 4, else read 0
package uart_regmap_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_INT_EN = 3'h1;
  localparam logic [2:0] ADDR_INT_STAT = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_ENH_FUNC = 3'h2;
  localparam logic [2:0] ADDR_RESUME_ONE = 3'h4;
  localparam logic [2:0] ADDR_RESUME_TWO = 3'h5;
  localparam logic [2:0] ADDR_PAUSE_ONE = 3'h6;
  localparam logic [2:0] ADDR_PAUSE_TWO = 3'h7;

  // ************************************************************
  // field positions and masks
  // ************************************************************
  localparam int DIV_ACCESS_BIT = 7;
  localparam int LOOPBACK_BIT = 4;
  localparam int EXT_ENABLE_BIT = 4;
  localparam int MC_DTR_BIT = 0;
  localparam int MC_RTS_BIT = 1;
  localparam int MC_OUT1_BIT = 2;
  localparam int MC_OUT2_BIT = 3;
  localparam logic [7:0] ENH_KEY = 8'hbf;
  localparam logic [7:0] EXT_INT_EN_MASK = 8'hf0;
  localparam logic [7:0] EXT_INT_STAT_MASK = 8'h30;
  localparam logic [7:0] EXT_FIFO_CTRL_MASK = 8'h30;
  localparam logic [7:0] EXT_MODEM_CTRL_MASK = 8'he0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] LINE_CTRL_RST = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0] ENH_FUNC_RST = 8'h00;
  localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] MODEM_STAT_RST = 8'h00;
  localparam logic [4:0] PIN_IDLE = 5'h1f;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic chip_sel_n;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [7:0] line_ctrl;
    logic [7:0] int_en;
    logic [7:0] modem_ctrl;
    logic [7:0] enh_func;
    logic [7:0] fifo_ctrl;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] resume_one;
    logic [7:0] resume_two;
    logic [7:0] pause_one;
    logic [7:0] pause_two;
  } cfg_s;

  typedef struct packed {
    logic hold_wr;
    logic hold_rd;
    logic fifo_wr;
    logic int_stat_rd;
    logic line_stat_rd;
    logic [7:0] data;
  } core_evt_s;

endpackage : uart_regmap_pkg

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] IDLE = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ************************************************************
  // three stages; only agreeing later stages update the output
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          stable[i] <= IDLE[i];
        end else if (s2_reg[i] == s3_reg[i]) begin
          stable[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// ---- uart_regmap_loopback.sv ----
`timescale 1ns/1ps
module uart_regmap_loopback
  import uart_regmap_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h3c, // arbitrary value
  parameter logic [7:0] IDENTITY = 8'h5a  // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host register bus
  input wire bus_req_s bus,
  output logic [7:0] data_out,
  output logic data_oe,
  // transceiver core side
  input wire logic [7:0] core_rx_data,
  input wire logic [7:0] core_int_stat,
  input wire logic [7:0] core_line_stat,
  input wire logic tsr_serial,
  output logic rsr_serial,
  output cfg_s cfg,
  output core_evt_s evt,
  // serial and modem pins
  input wire logic rx_pin,
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  input wire logic cd_n_pin,
  input wire logic ri_n_pin,
  output logic tx_pin,
  output logic rts_n,
  output logic dtr_n,
  output logic general_output_one_n,
  output logic general_output_two_n
);

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] line_ctrl_reg;
  logic [7:0] int_en_reg;
  logic [7:0] modem_ctrl_reg;
  logic [7:0] enh_func_reg;
  logic [7:0] fifo_ctrl_reg;
  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  logic [7:0] resume_one_reg;
  logic [7:0] resume_two_reg;
  logic [7:0] pause_one_reg;
  logic [7:0] pause_two_reg;
  logic [7:0] scratch_reg;
  logic [7:0] modem_stat_reg;
  logic [7:0] modem_stat_next;
  logic [7:0] read_next;
  logic [4:0] pins_stable;
  logic [3:0] pin_asserted;
  logic [3:0] loop_src;
  logic [3:0] stat_src;
  logic [3:0] delta_set;
  logic wr_hit;
  logic rd_hit;
  logic key_mode;
  logic div_access;
  logic div_zero;
  logic ext_on;
  logic loopback;

  function automatic logic [7:0] ext_gate(input logic [7:0] v, input logic [7:0] m, input logic on);
    ext_gate = on ? v : (v & ~m);
  endfunction : ext_gate

  // ************************************************************
  // decode
  // ************************************************************
  assign wr_hit = bus.wr && !bus.chip_sel_n;
  assign rd_hit = bus.rd && !bus.chip_sel_n;
  assign key_mode = (line_ctrl_reg == ENH_KEY);
  assign div_access = line_ctrl_reg[DIV_ACCESS_BIT];
  assign div_zero = (div_low_reg == 8'h00) && (div_high_reg == 8'h00);
  assign ext_on = enh_func_reg[EXT_ENABLE_BIT];
  assign loopback = modem_ctrl_reg[LOOPBACK_BIT];

  // ************************************************************
  // host writes
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      line_ctrl_reg <= LINE_CTRL_RST;
    end else if (wr_hit && bus.addr == ADDR_LINE_CTRL) begin
      line_ctrl_reg <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_low_reg <= DIV_RST;
      div_high_reg <= DIV_RST;
    end else if (wr_hit && div_access) begin
      if (bus.addr == ADDR_DIV_LOW) begin
        div_low_reg <= bus.wdata;
      end
      if (bus.addr == ADDR_DIV_HIGH) begin
        div_high_reg <= bus.wdata;
      end
    end
  end

  // extended bits written while hidden store as zero; bits set before hiding are kept
  always_ff @(posedge clk) begin
    if (rst) begin
      int_en_reg <= INT_EN_RST;
    end else if (wr_hit && !div_access && bus.addr == ADDR_INT_EN) begin
      int_en_reg <= ext_gate(bus.wdata, EXT_INT_EN_MASK, ext_on);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enh_func_reg <= ENH_FUNC_RST;
      fifo_ctrl_reg <= FIFO_CTRL_RST;
    end else if (wr_hit && bus.addr == ADDR_ENH_FUNC) begin
      if (key_mode) begin
        enh_func_reg <= bus.wdata;
      end else begin
        fifo_ctrl_reg <= ext_gate(bus.wdata, EXT_FIFO_CTRL_MASK, ext_on);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      modem_ctrl_reg <= MODEM_CTRL_RST;
      scratch_reg <= SCRATCH_RST;
    end else if (wr_hit && !key_mode) begin
      if (bus.addr == ADDR_MODEM_CTRL) begin
        modem_ctrl_reg <= ext_gate(bus.wdata, EXT_MODEM_CTRL_MASK, ext_on);
      end
      if (bus.addr == ADDR_SCRATCH) begin
        scratch_reg <= bus.wdata;
      end
    end
  end

  // flow control characters only reachable behind the key
  always_ff @(posedge clk) begin
    if (rst) begin
      resume_one_reg <= CHAR_RST;
      resume_two_reg <= CHAR_RST;
      pause_one_reg <= CHAR_RST;
      pause_two_reg <= CHAR_RST;
    end else if (wr_hit && key_mode) begin
      case (bus.addr)
        ADDR_RESUME_ONE: resume_one_reg <= bus.wdata;
        ADDR_RESUME_TWO: resume_two_reg <= bus.wdata;
        ADDR_PAUSE_ONE: pause_one_reg <= bus.wdata;
        ADDR_PAUSE_TWO: pause_two_reg <= bus.wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // events toward the core
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      evt <= '0;
    end else begin
      evt.hold_wr <= wr_hit && !div_access && bus.addr == ADDR_HOLD;
      evt.hold_rd <= rd_hit && !div_access && bus.addr == ADDR_HOLD;
      evt.fifo_wr <= wr_hit && !key_mode && bus.addr == ADDR_INT_STAT;
      evt.int_stat_rd <= rd_hit && !key_mode && bus.addr == ADDR_INT_STAT;
      evt.line_stat_rd <= rd_hit && !key_mode && bus.addr == ADDR_LINE_STAT;
      evt.data <= bus.wdata;
    end
  end

  // core keeps flow control and all else running during loopback
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg.line_ctrl <= line_ctrl_reg;
      cfg.int_en <= ext_gate(int_en_reg, EXT_INT_EN_MASK, ext_on);
      cfg.modem_ctrl <= ext_gate(modem_ctrl_reg, EXT_MODEM_CTRL_MASK, ext_on);
      cfg.enh_func <= enh_func_reg;
      cfg.fifo_ctrl <= ext_gate(fifo_ctrl_reg, EXT_FIFO_CTRL_MASK, ext_on);
      cfg.div_low <= div_low_reg;
      cfg.div_high <= div_high_reg;
      cfg.resume_one <= resume_one_reg;
      cfg.resume_two <= resume_two_reg;
      cfg.pause_one <= pause_one_reg;
      cfg.pause_two <= pause_two_reg;
    end
  end

  // ************************************************************
  // pins and loopback path
  // ************************************************************
  pin_sync #(
    .W(5),
    .IDLE(PIN_IDLE)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .raw({rx_pin, cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin}),
    .stable(pins_stable)
  );

  // receive pin must idle high in loopback or a false break shows on exit
  always_ff @(posedge clk) begin
    if (rst) begin
      rsr_serial <= 1'b1;
      tx_pin <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      general_output_one_n <= 1'b1;
      general_output_two_n <= 1'b1;
    end else begin
      rsr_serial <= loopback ? tsr_serial : pins_stable[4];
      tx_pin <= loopback ? 1'b1 : tsr_serial;
      rts_n <= loopback ? 1'b1 : ~modem_ctrl_reg[MC_RTS_BIT];
      dtr_n <= loopback ? 1'b1 : ~modem_ctrl_reg[MC_DTR_BIT];
      general_output_one_n <= loopback ? 1'b1 : ~modem_ctrl_reg[MC_OUT1_BIT];
      general_output_two_n <= loopback ? 1'b1 : ~modem_ctrl_reg[MC_OUT2_BIT];
    end
  end

  // ************************************************************
  // modem status: order carrier, ring, set-ready, clear-to-send
  // ************************************************************
  assign pin_asserted = ~pins_stable[3:0];
  assign loop_src = {modem_ctrl_reg[MC_OUT2_BIT], modem_ctrl_reg[MC_OUT1_BIT],
                     modem_ctrl_reg[MC_DTR_BIT], modem_ctrl_reg[MC_RTS_BIT]};
  assign stat_src = loopback ? loop_src : pin_asserted;
  assign delta_set = {stat_src[3] ^ modem_stat_reg[7],
                      modem_stat_reg[6] & ~stat_src[2],
                      stat_src[1] ^ modem_stat_reg[5],
                      stat_src[0] ^ modem_stat_reg[4]};

  // a change in the read cycle still lands: set beats clear
  always_comb begin
    modem_stat_next[7:4] = stat_src;
    modem_stat_next[3:0] = modem_stat_reg[3:0];
    if (rd_hit && !key_mode && bus.addr == ADDR_MODEM_STAT) begin
      modem_stat_next[3:0] = 4'h0;
    end
    modem_stat_next[3:0] = modem_stat_next[3:0] | delta_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      modem_stat_reg <= MODEM_STAT_RST;
    end else begin
      modem_stat_reg <= modem_stat_next;
    end
  end

  // ************************************************************
  // host reads
  // ************************************************************
  always_comb begin
    read_next = 8'h00;
    case (bus.addr)
      ADDR_HOLD: begin
        if (div_access) begin
          read_next = div_zero ? REVISION : div_low_reg;
        end else begin
          read_next = core_rx_data;
        end
      end
      ADDR_INT_EN: begin
        if (div_access) begin
          read_next = div_zero ? IDENTITY : div_high_reg;
        end else begin
          read_next = ext_gate(int_en_reg, EXT_INT_EN_MASK, ext_on);
        end
      end
      ADDR_INT_STAT: begin
        read_next = key_mode ? enh_func_reg
                             : ext_gate(core_int_stat, EXT_INT_STAT_MASK, ext_on);
      end
      ADDR_LINE_CTRL: read_next = line_ctrl_reg;
      ADDR_MODEM_CTRL: begin
        read_next = key_mode ? resume_one_reg
                             : ext_gate(modem_ctrl_reg, EXT_MODEM_CTRL_MASK, ext_on);
      end
      ADDR_LINE_STAT: read_next = key_mode ? resume_two_reg : core_line_stat;
      ADDR_MODEM_STAT: read_next = key_mode ? pause_one_reg : modem_stat_reg;
      ADDR_SCRATCH: read_next = key_mode ? pause_two_reg : scratch_reg;
      default: read_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= rd_hit ? read_next : 8'h00;
      data_oe <= rd_hit;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  loop_enter_a: assert property (
    wr_hit && !key_mode && bus.addr == ADDR_MODEM_CTRL |=> loopback == $past(bus.wdata[LOOPBACK_BIT]))
    else $error("loopback bit not taken from write");
  tx_mark_a: assert property (loopback |=> tx_pin)
    else $error("transmit pin not at mark in loopback");
  modem_out_a: assert property (loopback |=> rts_n && dtr_n)
    else $error("modem outputs asserted in loopback");
  loop_path_a: assert property (loopback |=> rsr_serial == $past(tsr_serial))
    else $error("receive input not fed from transmit shift");
  loop_status_a: assert property (
    loopback |=> modem_stat_reg[7:4] == $past({modem_ctrl_reg[3], modem_ctrl_reg[2],
                                                modem_ctrl_reg[0], modem_ctrl_reg[1]}))
    else $error("modem status follows pins in loopback");
  hold_write_a: assert property (
    wr_hit && !div_access && bus.addr == ADDR_HOLD |=> evt.hold_wr && evt.data == $past(bus.wdata))
    else $error("transmit holding write lost");
  div_high_a: assert property (
    wr_hit && div_access && bus.addr == ADDR_DIV_HIGH |=> div_high_reg == $past(bus.wdata))
    else $error("divisor high byte not written");
  ident_read_a: assert property (
    rd_hit && div_access && div_zero && bus.addr == ADDR_INT_EN |=> data_oe && data_out == IDENTITY)
    else $error("identity not returned");
  key_func_a: assert property (
    wr_hit && key_mode && bus.addr == ADDR_ENH_FUNC |=> enh_func_reg == $past(bus.wdata) && !evt.fifo_wr)
    else $error("enhanced function write misrouted");
  pause_two_a: assert property (
    wr_hit && key_mode && bus.addr == ADDR_PAUSE_TWO |=> pause_two_reg == $past(bus.wdata) && $stable(scratch_reg))
    else $error("pause character two misrouted");
  stat_write_a: assert property (
    wr_hit && !key_mode && (bus.addr == ADDR_LINE_STAT || bus.addr == ADDR_MODEM_STAT) |=>
      $stable({line_ctrl_reg, int_en_reg, modem_ctrl_reg, enh_func_reg, fifo_ctrl_reg, div_low_reg, div_high_reg,
               resume_one_reg, resume_two_reg, pause_one_reg, pause_two_reg, scratch_reg}) ##1 $stable(cfg))
    else $error("reserved write changed state");
  ext_hidden_a: assert property (!ext_on ##1 !ext_on |-> cfg.int_en[7:4] == 4'h0)
    else $error("extended enable bits visible");

endmodule : uart_regmap_loopback

// ---- far_side_model.sv ----
`timescale 1ns/1ps
module far_side_model (
  // clock
  input wire logic clk,
  // modem pin levels asked for by the bench
  input wire logic [3:0] mdm_n,
  // serial and modem pins toward the device
  output logic tsr_serial,
  output logic rx_pin,
  output logic cd_n_pin,
  output logic ri_n_pin,
  output logic dsr_n_pin,
  output logic cts_n_pin
);
  logic [6:0] lfsr_reg = 7'h5b;
  // irregular stream, so a stuck or delayed loop path shows up
  always @(negedge clk) begin
    lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
  end
  assign tsr_serial = lfsr_reg[0];
  assign rx_pin = 1'b1;
  assign {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin} = mdm_n;
endmodule : far_side_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import uart_regmap_pkg::*;
  localparam logic [7:0] REV_CODE = 8'h27; // arbitrary value
  localparam logic [7:0] ID_CODE = 8'h6e; // arbitrary value
  localparam bus_req_s BUS_IDLE = '{1'b1, 1'b0, 1'b0, 3'h0, 8'h00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  bus_req_s bus = BUS_IDLE;
  logic [7:0] data_out;
  logic [7:0] core_rx_data = 8'h00;
  logic [7:0] core_int_stat = 8'h00;
  logic [7:0] core_line_stat = 8'h00;
  logic data_oe, tsr_serial, rsr_serial, rx_pin, cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin;
  logic tx_pin, rts_n, dtr_n, out1_n, out2_n;
  logic [3:0] mdm_n = 4'hf;
  core_evt_s evt;
  cfg_s cfg;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] v, mc, scr;

  always #25 clk = ~clk;

  uart_regmap_loopback #(.REVISION(REV_CODE), .IDENTITY(ID_CODE)) uart_regmap_loopback_inst (
    .clk(clk), .rst(rst), .bus(bus), .data_out(data_out), .data_oe(data_oe),
    .core_rx_data(core_rx_data), .core_int_stat(core_int_stat), .core_line_stat(core_line_stat),
    .tsr_serial(tsr_serial), .rsr_serial(rsr_serial), .cfg(cfg), .evt(evt),
    .rx_pin(rx_pin), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin), .cd_n_pin(cd_n_pin),
    .ri_n_pin(ri_n_pin), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n),
    .general_output_one_n(out1_n), .general_output_two_n(out2_n));

  far_side_model far_side_model_inst (
    .clk(clk), .mdm_n(mdm_n), .tsr_serial(tsr_serial), .rx_pin(rx_pin), .cd_n_pin(cd_n_pin),
    .ri_n_pin(ri_n_pin), .dsr_n_pin(dsr_n_pin), .cts_n_pin(cts_n_pin));

  // ****************************************
  // expectations and bus cycles
  // ****************************************
  // loopback feeds cd, ri, dsr, cts from out2, out1, dtr, rts
  function automatic logic [7:0] ms_loop(input logic [7:0] m);
    return {m[3], m[2], m[0], m[1], 4'h0};
  endfunction : ms_loop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // tasks start and end at a falling edge; only idle releases the request
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    bus = '{1'b0, 1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    chk({data_oe, data_out & m}, {1'b1, e & m});
  endtask : rd

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus = '{1'b0, 1'b0, 1'b1, a, d};
    @(negedge clk);
  endtask : wr

  task automatic idle(input int n);
    bus = BUS_IDLE;
    repeat (n) @(negedge clk);
    chk({data_oe, data_out}, 9'h000);
  endtask : idle

  task automatic tally_and_finish;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(9));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rd(ADDR_LINE_CTRL, LINE_CTRL_RST);
    rd(ADDR_INT_EN, INT_EN_RST);
    rd(ADDR_MODEM_CTRL, MODEM_CTRL_RST);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(ADDR_SCRATCH, v);
      rd(ADDR_SCRATCH, v);
      wr(ADDR_INT_EN, v);
      rd(ADDR_INT_EN, v & ~EXT_INT_EN_MASK);
      chk(cfg.int_en, v & ~EXT_INT_EN_MASK);
      core_rx_data = 8'($urandom);
      core_int_stat = 8'($urandom);
      core_line_stat = 8'($urandom);
      rd(ADDR_HOLD, core_rx_data);
      chk(evt.hold_rd, 1'b1);
      rd(ADDR_INT_STAT, core_int_stat & ~EXT_INT_STAT_MASK);
      chk(evt.int_stat_rd, 1'b1);
      rd(ADDR_LINE_STAT, core_line_stat);
      chk(evt.line_stat_rd, 1'b1);
      wr(ADDR_HOLD, v);
      chk({evt.hold_wr, evt.data}, {1'b1, v});
      wr(ADDR_INT_STAT, v);
      chk({evt.fifo_wr, evt.data}, {1'b1, v});
    end
    scr = v;
    wr(ADDR_MODEM_CTRL, 8'he0);
    chk(cfg.fifo_ctrl, scr & ~EXT_FIFO_CTRL_MASK);
    rd(ADDR_MODEM_CTRL, 8'h00);
    wr(ADDR_LINE_CTRL, 8'h80);
    rd(ADDR_LINE_CTRL, 8'h80);
    rd(ADDR_DIV_LOW, REV_CODE);
    rd(ADDR_DIV_HIGH, ID_CODE);
    v = 8'($urandom) | 8'h01;
    wr(ADDR_DIV_LOW, v);
    chk(evt.hold_wr, 1'b0);
    rd(ADDR_DIV_LOW, v);
    wr(ADDR_DIV_HIGH, ~v);
    rd(ADDR_DIV_HIGH, ~v);
    chk({cfg.div_low, cfg.div_high}, {v, ~v});
    wr(ADDR_DIV_LOW, 8'h00);
    wr(ADDR_DIV_HIGH, 8'h00);
    rd(ADDR_DIV_LOW, REV_CODE);
    wr(ADDR_LINE_CTRL, ENH_KEY);
    for (int k = 7; k >= 2; k--) begin
      if (k != 3) begin
        mc = 8'($urandom);
        wr(3'(k), mc);
        rd(3'(k), mc);
      end
    end
    chk(cfg.enh_func, mc);
    wr(ADDR_ENH_FUNC, 8'h10);
    rd(ADDR_ENH_FUNC, 8'h10);
    wr(ADDR_LINE_CTRL, 8'h00);
    rd(ADDR_SCRATCH, scr);
    bus = '{1'b1, 1'b0, 1'b1, ADDR_SCRATCH, ~scr};
    @(negedge clk);
    rd(ADDR_SCRATCH, scr);
    wr(ADDR_LINE_STAT, 8'hff);
    wr(ADDR_MODEM_STAT, 8'hff);
    rd(ADDR_MODEM_CTRL, 8'h00);
    wr(ADDR_INT_EN, 8'hff);
    rd(ADDR_INT_EN, 8'hff);
    for (int i = 0; i < 4; i++) begin
      mc = {4'h1, 4'($urandom)};
      wr(ADDR_MODEM_CTRL, mc);
      idle(3);
      rd(ADDR_MODEM_STAT, ms_loop(mc), 8'hf0);
      chk(cfg.modem_ctrl, mc);
      idle(1);
      mdm_n = 4'($urandom);
      for (int k = 0; k < 8; k++) begin
        chk({tx_pin, rts_n, dtr_n, out1_n, out2_n, rsr_serial}, {5'h1f, tsr_serial});
        @(negedge clk);
      end
      rd(ADDR_MODEM_STAT, ms_loop(mc));
    end
    wr(ADDR_MODEM_CTRL, 8'h0f);
    idle(8);
    chk({tx_pin, rts_n, dtr_n, out1_n, out2_n, rsr_serial}, {tsr_serial, 5'h01});
    rd(ADDR_MODEM_STAT, {~mdm_n, 4'h0}, 8'hf0);
    idle(2);
    tally_and_finish();
  end
endmodule : testbench
